// file: brlsu_pkg.sv
// Constants, types and register map of the base-relative load/store unit
package brlsu_pkg;

  // Operation codes
  localparam logic [3:0] OP_LOCAL_WORD_LOAD            = 4'h0;
  localparam logic [3:0] OP_LOCAL_DWORD_LOAD           = 4'h1;
  localparam logic [3:0] OP_LOCAL_WORD_STORE           = 4'h2;
  localparam logic [3:0] OP_LOCAL_DWORD_STORE          = 4'h3;
  localparam logic [3:0] OP_GLOBAL_TEST_AND_SET        = 4'h4;
  localparam logic [3:0] OP_GLOBAL_BYTE_ORG_BYTE_LOAD  = 4'h5;
  localparam logic [3:0] OP_GLOBAL_BYTE_ORG_WORD_LOAD  = 4'h6;
  localparam logic [3:0] OP_GLOBAL_BYTE_ORG_DWORD_LOAD = 4'h7;
  localparam logic [3:0] OP_GLOBAL_BYTE_ORG_BYTE_STORE = 4'h8;
  localparam logic [3:0] OP_GLOBAL_BYTE_ORG_WORD_STORE = 4'h9;
  localparam logic [3:0] OP_GLOBAL_BYTE_ORG_DWORD_STORE = 4'hA;
  localparam logic [3:0] OP_GLOBAL_WORD_ORG_WORD_LOAD  = 4'hB;
  localparam logic [3:0] OP_GLOBAL_WORD_ORG_DWORD_LOAD = 4'hC;
  localparam logic [3:0] OP_GLOBAL_WORD_ORG_WORD_STORE = 4'hD;
  localparam logic [3:0] OP_GLOBAL_WORD_ORG_DWORD_STORE = 4'hE;

  // Access sizes on the memory port
  localparam logic [1:0] SIZE_BYTE  = 2'h0;
  localparam logic [1:0] SIZE_WORD  = 2'h1;
  localparam logic [1:0] SIZE_DWORD = 2'h2;

  // Address ranges
  localparam logic [21:0] LOCAL_END      = 22'h0E_FFFF;
  localparam logic [21:0] GLOBAL_START   = 22'h0F_0000;
  localparam logic [21:0] GLOBAL_END     = 22'h0F_FFFF;
  localparam logic [21:0] BYTE_ORG_W_END = 22'h0F_FFFE;
  localparam logic [21:0] BYTE_ORG_D_END = 22'h0F_FFFC;
  localparam logic [21:0] WORD_ORG_D_END = 22'h0F_FFFE;

  // Error identifiers
  localparam logic [31:0] WORD_ORG_ERR_ID   = 32'h0000_1A01;
  localparam logic [15:0] TRANSFER_ERR_CODE = 16'h0001;

  // Register map (byte addresses)
  localparam logic [7:0] REG_BASE_ADDRESS = 8'h00;
  localparam logic [7:0] REG_ACCU_ONE     = 8'h04;
  localparam logic [7:0] REG_ACCU_TWO     = 8'h08;
  localparam logic [7:0] REG_STATUS       = 8'h0C;
  localparam logic [7:0] REG_CONFIG       = 8'h10;
  localparam logic [7:0] REG_INT_STACK    = 8'h14;
  localparam logic [7:0] REG_IRQ_STATUS   = 8'h18;
  localparam logic [7:0] REG_IRQ_MASK     = 8'h1C;

  // Config fields
  localparam int CFG_HANDLER_BIT    = 8;
  localparam int CFG_STOP_CLEAR_BIT = 9;

  // Interrupt event bits
  localparam int EV_ERROR = 0;
  localparam int EV_STOP  = 1;
  localparam int EV_DONE  = 2;
  localparam int EV_BITS  = 3;

  // Reset values
  localparam logic [7:0] SLOT_ID_RESET = 8'h01;

  typedef enum logic [1:0] {
    BRLSU_IDLE,
    BRLSU_ACCESS,
    BRLSU_TAS_WRITE
  } brlsu_state_t;

  typedef struct packed {
    logic       legal;
    logic       load;
    logic       store;
    logic       tas;
    logic       is_global;
    logic       word_org;
    logic [1:0] size;
  } brlsu_opinfo_t;

endpackage

// file: brlsu_core.sv
// Base-relative load/store unit with register port and memory port
`timescale 1ns/1ns
`default_nettype none
module brlsu_core
  import brlsu_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Operation request
  input  wire logic        op_start,
  input  wire logic [3:0]  op_code,
  input  wire logic [15:0] op_offset,
  output logic             op_busy,
  output logic             op_done,
  output logic             handler_call,
  output logic             stop_mode,
  output logic             condition_code_upper,
  output logic             condition_code_lower,
  // Memory port
  output logic             mem_req,
  output logic             mem_we,
  output logic             mem_lock,
  output logic             mem_global,
  output logic             mem_word_org,
  output logic      [1:0]  mem_size,
  output logic      [19:0] mem_addr,
  output logic      [31:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  // Interrupt
  output logic             irq
);

  typedef struct packed {
    brlsu_state_t         state;
    logic [19:0]          base_address_register;
    logic [31:0]          accumulator_one;
    logic [31:0]          accumulator_two;
    logic                 cc_upper;
    logic                 cc_lower;
    logic [15:0]          interrupt_stack;
    logic [EV_BITS-1:0]   irq_stat;
    logic [EV_BITS-1:0]   irq_mask;
    logic [7:0]           slot_id;
    logic                 handler_loaded;
    logic                 stop;
    brlsu_opinfo_t        info;
    logic                 busy;
    logic                 done;
    logic                 hcall;
    logic                 req;
    logic                 we;
    logic                 lock;
    logic                 is_global;
    logic                 word_org;
    logic [1:0]           size;
    logic [19:0]          addr;
    logic [31:0]          wdata;
    logic [31:0]          rdata;
    logic                 irq;
  } brlsu_regs_t;

  brlsu_regs_t s;
  brlsu_regs_t next_s;

  // Decode of an operation code into its access properties
  function automatic brlsu_opinfo_t decode(input logic [3:0] code);
    brlsu_opinfo_t d;
    d = '0;
    d.legal = 1'b1;
    case (code)
      OP_LOCAL_WORD_LOAD:
      begin
        d.load = 1'b1;
        d.size = SIZE_WORD;
      end
      OP_LOCAL_DWORD_LOAD:
      begin
        d.load = 1'b1;
        d.size = SIZE_DWORD;
      end
      OP_LOCAL_WORD_STORE:
      begin
        d.store = 1'b1;
        d.size  = SIZE_WORD;
      end
      OP_LOCAL_DWORD_STORE:
      begin
        d.store = 1'b1;
        d.size  = SIZE_DWORD;
      end
      OP_GLOBAL_TEST_AND_SET:
      begin
        d.tas       = 1'b1;
        d.is_global = 1'b1;
        d.size   = SIZE_WORD;
      end
      OP_GLOBAL_BYTE_ORG_BYTE_LOAD, OP_GLOBAL_BYTE_ORG_WORD_LOAD,
      OP_GLOBAL_BYTE_ORG_DWORD_LOAD:
      begin
        d.load      = 1'b1;
        d.is_global = 1'b1;
        d.size      = 2'(code - OP_GLOBAL_BYTE_ORG_BYTE_LOAD);
      end
      OP_GLOBAL_BYTE_ORG_BYTE_STORE, OP_GLOBAL_BYTE_ORG_WORD_STORE,
      OP_GLOBAL_BYTE_ORG_DWORD_STORE:
      begin
        d.store     = 1'b1;
        d.is_global = 1'b1;
        d.size   = 2'(code - OP_GLOBAL_BYTE_ORG_BYTE_STORE);
      end
      OP_GLOBAL_WORD_ORG_WORD_LOAD, OP_GLOBAL_WORD_ORG_DWORD_LOAD:
      begin
        d.load      = 1'b1;
        d.is_global = 1'b1;
        d.word_org = 1'b1;
        d.size     = (code == OP_GLOBAL_WORD_ORG_WORD_LOAD) ? SIZE_WORD : SIZE_DWORD;
      end
      OP_GLOBAL_WORD_ORG_WORD_STORE, OP_GLOBAL_WORD_ORG_DWORD_STORE:
      begin
        d.store     = 1'b1;
        d.is_global = 1'b1;
        d.word_org = 1'b1;
        d.size     = (code == OP_GLOBAL_WORD_ORG_WORD_STORE) ? SIZE_WORD : SIZE_DWORD;
      end
      default:
      begin
        d.legal = 1'b0;
      end
    endcase
    return d;
  endfunction

  // Sum kept 22 bits wide and unsigned so underflow and overflow are caught
  function automatic logic [21:0] eff_addr(input logic [19:0] base,
                                           input logic [15:0] offset);
    return {2'b00, base} + {{6{offset[15]}}, offset};
  endfunction

  function automatic logic range_ok(input brlsu_opinfo_t d, input logic [21:0] a);
    logic       ok;
    logic [21:0] last;
    ok   = 1'b0;
    last = GLOBAL_END;
    if (!d.is_global)
    begin
      ok = (a <= LOCAL_END);
    end
    else if (d.tas)
    begin
      ok = (a >= GLOBAL_START) && (a <= GLOBAL_END);
    end
    else
    begin
      if (d.word_org)
      begin
        last = (d.size == SIZE_DWORD) ? WORD_ORG_D_END : GLOBAL_END;
      end
      else
      begin
        case (d.size)
          SIZE_WORD:  last = BYTE_ORG_W_END;
          SIZE_DWORD: last = BYTE_ORG_D_END;
          default:    last = GLOBAL_END;
        endcase
      end
      ok = (a >= GLOBAL_START) && (a <= last);
    end
    return ok;
  endfunction

  // Placement of loaded data in accumulator_one
  function automatic logic [31:0] place(input logic [1:0] size, input logic [31:0] data);
    logic [31:0] v;
    case (size)
      SIZE_BYTE: v = {24'h00_0000, data[7:0]};
      SIZE_WORD: v = {16'h0000, data[15:0]};
      default:   v = data;
    endcase
    return v;
  endfunction

  always_comb
  begin
    logic [21:0]        ea;
    brlsu_opinfo_t      d;
    logic [EV_BITS-1:0] ev;
    logic [7:0]         held;
    ea     = '0;
    d      = '0;
    ev     = '0;
    held   = mem_rdata[7:0];
    next_s = s;
    next_s.done  = 1'b0;
    next_s.hcall = 1'b0;
    next_s.rdata = '0;

    // Register writes
    if (reg_wr)
    begin
      case (reg_addr)
        REG_BASE_ADDRESS: next_s.base_address_register = reg_wdata[19:0];
        REG_ACCU_ONE:
        begin
          if (s.state == BRLSU_IDLE)
          begin
            next_s.accumulator_one = reg_wdata;
          end
        end
        REG_ACCU_TWO:
        begin
          if (s.state == BRLSU_IDLE)
          begin
            next_s.accumulator_two = reg_wdata;
          end
        end
        REG_CONFIG:
        begin
          next_s.slot_id        = reg_wdata[7:0];
          next_s.handler_loaded = reg_wdata[CFG_HANDLER_BIT];
          if (reg_wdata[CFG_STOP_CLEAR_BIT])
          begin
            next_s.stop = 1'b0;
          end
        end
        REG_IRQ_STATUS: next_s.irq_stat = s.irq_stat & ~reg_wdata[EV_BITS-1:0];
        REG_IRQ_MASK:   next_s.irq_mask = reg_wdata[EV_BITS-1:0];
        default:        next_s.irq_mask = next_s.irq_mask;
      endcase
    end

    // Register reads, answered in the following cycle
    if (reg_rd)
    begin
      case (reg_addr)
        REG_BASE_ADDRESS: next_s.rdata = {12'h000, s.base_address_register};
        REG_ACCU_ONE:     next_s.rdata = s.accumulator_one;
        REG_ACCU_TWO:     next_s.rdata = s.accumulator_two;
        REG_STATUS:       next_s.rdata = {28'h000_0000, s.stop, s.busy, s.cc_upper,
                                          s.cc_lower};
        REG_CONFIG:       next_s.rdata = {23'h00_0000, s.handler_loaded, s.slot_id};
        REG_INT_STACK:    next_s.rdata = {16'h0000, s.interrupt_stack};
        REG_IRQ_STATUS:   next_s.rdata = {29'h0000_0000, s.irq_stat};
        REG_IRQ_MASK:     next_s.rdata = {29'h0000_0000, s.irq_mask};
        default:          next_s.rdata = '0;
      endcase
    end

    case (s.state)
      BRLSU_IDLE:
      begin
        // Requests during stop mode are ignored
        if (op_start && !s.stop)
        begin
          d  = decode(op_code);
          ea = eff_addr(s.base_address_register, op_offset);
          next_s.info = d;
          if (!d.legal)
          begin
            next_s.done = 1'b1;
          end
          else if (!range_ok(d, ea))
          begin
            // No memory cycle is started for a failed check
            next_s.done = 1'b1;
            ev[EV_ERROR] = 1'b1;
            if (d.word_org)
            begin
              next_s.accumulator_one = WORD_ORG_ERR_ID;
            end
            if (s.handler_loaded)
            begin
              next_s.hcall = 1'b1;
            end
            else
            begin
              next_s.stop            = 1'b1;
              next_s.interrupt_stack = TRANSFER_ERR_CODE;
              ev[EV_STOP]            = 1'b1;
            end
          end
          else
          begin
            next_s.state    = BRLSU_ACCESS;
            next_s.busy     = 1'b1;
            next_s.req      = 1'b1;
            next_s.we       = d.store;
            next_s.lock     = d.tas;
            next_s.is_global = d.is_global;
            next_s.word_org = d.word_org;
            next_s.size     = d.size;
            next_s.addr     = ea[19:0];
            next_s.wdata    = place(d.size, s.accumulator_one);
          end
        end
      end
      BRLSU_ACCESS:
      begin
        if (mem_ack)
        begin
          next_s.req = 1'b0;
          if (s.info.tas)
          begin
            if (held == 8'h00)
            begin
              // Lock stays up so no other master slips in between
              next_s.state    = BRLSU_TAS_WRITE;
              next_s.req      = 1'b1;
              next_s.we       = 1'b1;
              next_s.size     = SIZE_BYTE;
              next_s.wdata    = {24'h00_0000, s.slot_id};
              next_s.cc_upper = 1'b0;
              next_s.cc_lower = 1'b0;
            end
            else
            begin
              next_s.state    = BRLSU_IDLE;
              next_s.busy     = 1'b0;
              next_s.lock     = 1'b0;
              next_s.done     = 1'b1;
              next_s.cc_upper = (held == s.slot_id);
              next_s.cc_lower = (held != s.slot_id);
              ev[EV_DONE]     = 1'b1;
            end
          end
          else
          begin
            if (s.info.load)
            begin
              next_s.accumulator_two = s.accumulator_one;
              next_s.accumulator_one = place(s.size, mem_rdata);
            end
            next_s.state = BRLSU_IDLE;
            next_s.busy  = 1'b0;
            next_s.we    = 1'b0;
            next_s.done  = 1'b1;
            ev[EV_DONE]  = 1'b1;
          end
        end
      end
      BRLSU_TAS_WRITE:
      begin
        if (mem_ack)
        begin
          next_s.state = BRLSU_IDLE;
          next_s.req   = 1'b0;
          next_s.we    = 1'b0;
          next_s.lock  = 1'b0;
          next_s.busy  = 1'b0;
          next_s.done  = 1'b1;
          ev[EV_DONE]  = 1'b1;
        end
      end
      default:
      begin
        next_s.state = BRLSU_IDLE;
      end
    endcase

    // Set wins over a clear in the same cycle
    next_s.irq_stat = next_s.irq_stat | ev;
    next_s.irq      = |(next_s.irq_stat & next_s.irq_mask);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s         <= '0;
      s.state   <= BRLSU_IDLE;
      s.slot_id <= SLOT_ID_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign reg_rdata            = s.rdata;
  assign op_busy              = s.busy;
  assign op_done              = s.done;
  assign handler_call         = s.hcall;
  assign stop_mode            = s.stop;
  assign condition_code_upper = s.cc_upper;
  assign condition_code_lower = s.cc_lower;
  assign mem_req              = s.req;
  assign mem_we               = s.we;
  assign mem_lock             = s.lock;
  assign mem_global           = s.is_global;
  assign mem_word_org         = s.word_org;
  assign mem_size             = s.size;
  assign mem_addr             = s.addr;
  assign mem_wdata            = s.wdata;
  assign irq                  = s.irq;

endmodule
`default_nettype wire

// file: brlsu_properties.sv
// Port assertions for the load/store unit
`timescale 1ns/1ns
`default_nettype none
module brlsu_checker
  import brlsu_pkg::*;
(
  // Clock, reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Status
  input wire logic        op_done,
  input wire logic        handler_call,
  input wire logic        condition_code_upper,
  input wire logic        condition_code_lower,
  // Memory port
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic        mem_lock,
  input wire logic        mem_global,
  input wire logic        mem_word_org,
  input wire logic [1:0]  mem_size,
  input wire logic [19:0] mem_addr,
  input wire logic        mem_ack,
  input wire logic [31:0] mem_rdata
);
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic tas_rd;
  assign tas_rd = mem_req && mem_lock && !mem_we;

  property p_access_done;
    mem_req && mem_ack && !mem_lock |=> op_done && !mem_req;
  endproperty
  a_access_done: assert property (p_access_done) else $error("no done after access");
  property p_tas_shape;
    tas_rd |-> mem_global && mem_size == SIZE_WORD;
  endproperty
  a_tas_shape: assert property (p_tas_shape) else $error("bad test-and-set read");
  property p_tas_claim;
    tas_rd && mem_ack && mem_rdata[7:0] == 8'h00 |=> mem_req && mem_lock && mem_we
      && mem_size == SIZE_BYTE && $stable(mem_addr);
  endproperty
  a_tas_claim: assert property (p_tas_claim) else $error("claim not locked");
  property p_tas_busy;
    tas_rd && mem_ack && mem_rdata[7:0] != 8'h00 |=> op_done && !mem_lock
      && (condition_code_upper != condition_code_lower);
  endproperty
  a_tas_busy: assert property (p_tas_busy) else $error("bad busy codes");
  property p_tas_free;
    mem_req && mem_lock && mem_we && mem_ack |=> op_done && !mem_lock
      && !condition_code_upper && !condition_code_lower;
  endproperty
  a_tas_free: assert property (p_tas_free) else $error("bad claim codes");
  property p_local_range;
    mem_req && !mem_global |-> mem_addr <= 20'hE_FFFF;
  endproperty
  a_local_range: assert property (p_local_range) else $error("local out of range");
  property p_global_range;
    mem_req && mem_global |-> mem_addr >= 20'hF_0000;
  endproperty
  a_global_range: assert property (p_global_range) else $error("global out of range");
  property p_bo_dword;
    mem_req && mem_global && !mem_word_org && mem_size == SIZE_DWORD |-> mem_addr <= 20'hF_FFFC;
  endproperty
  a_bo_dword: assert property (p_bo_dword) else $error("byte-org dword range");
  property p_wo_dword;
    mem_req && mem_word_org && mem_size == SIZE_DWORD |-> mem_addr <= 20'hF_FFFE;
  endproperty
  a_wo_dword: assert property (p_wo_dword) else $error("word-org dword range");
  property p_err_quiet;
    handler_call |-> op_done && !mem_req ##1 !mem_req;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("access after error");
endmodule
bind brlsu_core brlsu_checker i_brlsu_checker (
  .clk_sys(clk_sys), .rst_n(rst_n), .op_done(op_done), .handler_call(handler_call),
  .condition_code_upper(condition_code_upper), .condition_code_lower(condition_code_lower),
  .mem_req(mem_req), .mem_we(mem_we), .mem_lock(mem_lock), .mem_global(mem_global),
  .mem_word_org(mem_word_org), .mem_size(mem_size), .mem_addr(mem_addr),
  .mem_ack(mem_ack), .mem_rdata(mem_rdata));
`default_nettype wire

// file: brlsu_mem_model.sv
// Behavioural local and global memory behind the unit's memory port
`timescale 1ns/1ns
`default_nettype none
module brlsu_mem_model
  import brlsu_pkg::*;
(
  // Clock, reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Memory port
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic        mem_global,
  input  wire logic [1:0]  mem_size,
  input  wire logic [19:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic      [31:0] mem_rdata,
  // Wait states per access
  input  wire logic [3:0]  wait_cycles
);
  logic [7:0]  store [logic [20:0]];
  logic [3:0]  cnt;
  logic [31:0] rd;
  logic [20:0] k;
  int          nb;

  // Little-endian lanes; unwritten bytes read as a free occupancy byte
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h5A5A_A5A5;
      cnt <= 4'h0;
    end
    else if (mem_ack || !mem_req || cnt < wait_cycles)
    begin
      // Released bus never shows a stale value
      mem_rdata <= ~mem_rdata;
      mem_ack <= 1'b0;
      cnt <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
    end
    else
    begin
      nb = (mem_size == SIZE_BYTE) ? 1 : (mem_size == SIZE_WORD) ? 2 : 4;
      rd = 32'h0000_0000;
      for (int i = 0; i < nb; i++)
      begin
        k = {mem_global, mem_addr + 20'(i)};
        rd[8*i +: 8] = store.exists(k) ? store[k] : 8'h00;
        if (mem_we)
          store[k] = mem_wdata[8*i +: 8];
      end
      mem_rdata <= rd;
      mem_ack <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: brlsu_tb_top.sv
// Self-checking bench for the base-relative load/store unit
`timescale 1ns/1ns
`default_nettype none
module brlsu_tb_top;
  import brlsu_pkg::*;
  logic        clk_sys, rst_n, reg_wr, reg_rd, op_start, op_busy, op_done, err_seen;
  logic        handler_call, stop_mode, cc_up, cc_lo, irq;
  logic        mem_req, mem_we, mem_lock, mem_global, mem_word_org, mem_ack;
  logic [1:0]  mem_size;
  logic [3:0]  op_code, wait_cycles;
  logic [7:0]  reg_addr;
  logic [15:0] op_offset;
  logic [19:0] mem_addr;
  logic [31:0] reg_wdata, reg_rdata, mem_wdata, mem_rdata;
  int          num_errors, n_tests, cycles;

  brlsu_core i_brlsu_core (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_start(op_start),
    .op_code(op_code), .op_offset(op_offset), .op_busy(op_busy), .op_done(op_done),
    .handler_call(handler_call), .stop_mode(stop_mode), .condition_code_upper(cc_up),
    .condition_code_lower(cc_lo), .mem_req(mem_req), .mem_we(mem_we), .mem_lock(mem_lock),
    .mem_global(mem_global), .mem_word_org(mem_word_org), .mem_size(mem_size),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .irq(irq));
  brlsu_mem_model i_brlsu_mem_model (
    .clk_sys(clk_sys), .rst_n(rst_n), .mem_req(mem_req), .mem_we(mem_we),
    .mem_global(mem_global), .mem_size(mem_size), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .wait_cycles(wait_cycles));

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // Bounded wait so a lost completion cannot hang the run
  task automatic op(input logic [3:0] c, input logic [15:0] o);
    int n;
    n = 0;
    @(posedge clk_sys);
    op_start <= 1'b1;
    op_code <= c;
    op_offset <= o;
    @(posedge clk_sys);
    op_start <= 1'b0;
    #1;
    chk(op_busy, !op_done);
    while (op_done !== 1'b1 && n < 100)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(n < 100, 1'b1);
    err_seen = handler_call;
  endtask

  task automatic st(input logic [3:0] c, input logic [15:0] o, input logic [31:0] d);
    wr(REG_ACCU_ONE, d);
    op(c, o);
  endtask

  task automatic ld(input logic [3:0] c, input logic [15:0] o, input logic [31:0] e);
    op(c, o);
    rd_chk(REG_ACCU_ONE, e);
  endtask

  task automatic rng(input logic [3:0] c, input logic [19:0] b, input logic [15:0] o,
                     input logic e);
    wr(REG_BASE_ADDRESS, {12'h000, b});
    op(c, o);
    chk(err_seen, e);
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      num_errors++;
      $display("MISMATCH at %0t: run too long", $time);
      stop_test();
    end
  end

  initial
  begin
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
    op_start = 1'b0; op_code = 4'h0; op_offset = 16'h0; wait_cycles = 4'h0;
    num_errors = 0; n_tests = 0; cycles = 0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk(REG_CONFIG, 32'h0000_0001);
    rd_chk(8'h20, 32'h0000_0000);
    wr(REG_CONFIG, 32'h0000_0103);
    wr(REG_IRQ_MASK, 32'h0000_0007);
    wr(REG_BASE_ADDRESS, 32'h000F_0000);
    st(OP_GLOBAL_BYTE_ORG_DWORD_STORE, 16'h0010, 32'h1234_5678);
    wr(REG_ACCU_ONE, 32'hAAAA_BBBB);
    ld(OP_GLOBAL_BYTE_ORG_BYTE_LOAD, 16'h0010, 32'h0000_0078);
    rd_chk(REG_ACCU_TWO, 32'hAAAA_BBBB);
    ld(OP_GLOBAL_BYTE_ORG_WORD_LOAD, 16'h0010, 32'h0000_5678);
    st(OP_GLOBAL_WORD_ORG_WORD_STORE, 16'h0012, 32'h9999_ABCD);
    st(OP_GLOBAL_BYTE_ORG_BYTE_STORE, 16'h0011, 32'h0000_00EE);
    ld(OP_GLOBAL_WORD_ORG_DWORD_LOAD, 16'h0010, 32'hABCD_EE78);
    rd_chk(REG_ACCU_TWO, 32'h0000_00EE);
    ld(OP_GLOBAL_WORD_ORG_WORD_LOAD, 16'h0012, 32'h0000_ABCD);
    st(OP_GLOBAL_WORD_ORG_DWORD_STORE, 16'h0020, 32'h0BAD_F00D);
    st(OP_GLOBAL_BYTE_ORG_WORD_STORE, 16'h0020, 32'h5555_1234);
    ld(OP_GLOBAL_BYTE_ORG_DWORD_LOAD, 16'h0020, 32'h0BAD_1234);
    wait_cycles <= 4'h3;
    wr(REG_BASE_ADDRESS, 32'h0000_0000);
    st(OP_LOCAL_DWORD_STORE, 16'h0010, 32'hCAFE_F00D);
    st(OP_LOCAL_WORD_STORE, 16'h0010, 32'h1111_2222);
    wr(REG_BASE_ADDRESS, 32'h0000_8010);
    ld(OP_LOCAL_DWORD_LOAD, 16'h8000, 32'hCAFE_2222);
    op(OP_LOCAL_WORD_LOAD, 16'h8000);
    rd_chk(REG_ACCU_TWO, 32'hCAFE_2222);
    wait_cycles <= 4'h1;
    wr(REG_BASE_ADDRESS, 32'h000F_0100);
    op(OP_GLOBAL_TEST_AND_SET, 16'h0000);
    chk({cc_up, cc_lo}, 2'b00);
    ld(OP_GLOBAL_BYTE_ORG_BYTE_LOAD, 16'h0000, 32'h0000_0003);
    op(OP_GLOBAL_TEST_AND_SET, 16'h0000);
    chk({cc_up, cc_lo}, 2'b10);
    st(OP_GLOBAL_BYTE_ORG_BYTE_STORE, 16'h0000, 32'h0000_0005);
    op(OP_GLOBAL_TEST_AND_SET, 16'h0000);
    chk({cc_up, cc_lo}, 2'b01);
    ld(OP_GLOBAL_BYTE_ORG_BYTE_LOAD, 16'h0000, 32'h0000_0005);
    st(OP_GLOBAL_BYTE_ORG_BYTE_STORE, 16'h0000, 32'h0000_0000);
    op(OP_GLOBAL_TEST_AND_SET, 16'h0000);
    chk({cc_up, cc_lo}, 2'b00);
    rng(OP_LOCAL_WORD_LOAD, 20'h0_0000, 16'hFFFF, 1'b1);
    rng(OP_LOCAL_DWORD_STORE, 20'hE_FFFF, 16'h0000, 1'b0);
    rng(OP_LOCAL_WORD_STORE, 20'hE_FFFF, 16'h0001, 1'b1);
    rng(OP_GLOBAL_BYTE_ORG_WORD_LOAD, 20'hF_FFFE, 16'h0000, 1'b0);
    rng(OP_GLOBAL_BYTE_ORG_WORD_STORE, 20'hF_FFFF, 16'h0000, 1'b1);
    rng(OP_GLOBAL_BYTE_ORG_DWORD_STORE, 20'hF_FFFD, 16'h0000, 1'b1);
    rng(OP_GLOBAL_BYTE_ORG_BYTE_LOAD, 20'hF_FFFF, 16'h0001, 1'b1);
    rng(OP_GLOBAL_WORD_ORG_WORD_STORE, 20'hF_FFFF, 16'h0000, 1'b0);
    rng(OP_GLOBAL_WORD_ORG_DWORD_LOAD, 20'hF_FFFF, 16'h0000, 1'b1);
    rd_chk(REG_ACCU_ONE, WORD_ORG_ERR_ID);
    rng(OP_GLOBAL_TEST_AND_SET, 20'hE_FFFF, 16'h0000, 1'b1);
    chk(irq, 1'b1);
    rd_chk(REG_IRQ_STATUS, 32'h0000_0005);
    wr(REG_IRQ_STATUS, 32'h0000_0007);
    rd_chk(REG_IRQ_STATUS, 32'h0000_0000);
    chk(irq, 1'b0);
    wr(REG_IRQ_MASK, 32'h0000_0004);
    rng(OP_GLOBAL_WORD_ORG_WORD_LOAD, 20'hE_FFFF, 16'h0000, 1'b1);
    rng(4'hF, 20'hF_0000, 16'h0000, 1'b0);
    rd_chk(REG_IRQ_STATUS, 32'h0000_0001);
    chk(irq, 1'b0);
    wr(REG_CONFIG, 32'h0000_0001);
    rng(OP_GLOBAL_BYTE_ORG_BYTE_STORE, 20'hE_FFFF, 16'h0000, 1'b0);
    chk(stop_mode, 1'b1);
    rd_chk(REG_INT_STACK, {16'h0000, TRANSFER_ERR_CODE});
    wr(REG_CONFIG, 32'h0000_0201);
    rd_chk(REG_STATUS, 32'h0000_0000);
    stop_test();
  end
endmodule
`default_nettype wire
